/* File: rtl/mrcr_pkg.sv */
// Shared constants and types of the magnetometer result and control registers
package mrcr_pkg;
    // ==========================================
    // Widths
    localparam int RAW_W = 20;
    localparam int AXIS_W = 16;
    localparam int VEC_W = 32;
    localparam int ADDR_W = 8;
    localparam int WDATA_W = 16;

    // ==========================================
    // Register offsets
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    localparam logic [7:0] X_RESULT_ADDR = 8'h11;
    localparam logic [7:0] Y_RESULT_ADDR = 8'h12;
    localparam logic [7:0] Z_RESULT_ADDR = 8'h13;
    localparam logic [7:0] VECTOR_RESULT_ADDR = 8'h18;
    localparam logic [7:0] INT_CFG_ADDR = 8'h20;
    localparam logic [7:0] MODE_CFG_ADDR = 8'h21;
    localparam logic [7:0] SETTING_LAST_ADDR = 8'h25;

    // ==========================================
    // Field layout of interrupt_output_config
    localparam int DATA_READY_FLAG_EN_BIT = 0;
    localparam int X_SW_EN_BIT = 1;
    localparam int Y_SW_EN_BIT = 2;
    localparam int Z_SW_EN_BIT = 3;
    localparam int V_SW_EN_BIT = 4;
    localparam int OVF_EN_BIT = 5;
    localparam int X_POL_BIT = 8;
    localparam int Y_POL_BIT = 9;
    localparam int Z_POL_BIT = 10;
    localparam int V_POL_BIT = 11;
    localparam logic [15:0] INT_CFG_WMASK = 16'h0f3f;
    localparam logic [15:0] INT_CFG_RESET = 16'h0000;

    // ==========================================
    // Field layout of mode_drive_range_config
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 4;
    localparam int DRIVE_BIT = 5;
    localparam int RANGE_BIT = 6;
    localparam int SELF_TEST_BIT = 7;
    localparam logic [7:0] MODE_CFG_RESET = 8'h00;
    localparam logic [4:0] MODE_SINGLE = 5'h01;
    localparam logic [4:0] MODE_CONT_LAST = 5'h10;

    // ==========================================
    // Status bit positions
    localparam int ST_DATA_READY_FLAG_BIT = 0;
    localparam int ST_OVF_BIT = 5;
    localparam int ST_OVERRUN_BIT = 6;
    localparam logic [7:0] ST_FIXED = 8'h80;

    // ==========================================
    // Clamping codes
    localparam logic signed [19:0] FULL_HI = 20'h0_7fff;
    localparam logic signed [19:0] FULL_LO = 20'hf_8000;
    localparam logic signed [19:0] WIDE_XY_HI = 20'h0_2c00;
    localparam logic signed [19:0] WIDE_XY_LO = 20'hf_d400;

    // ==========================================
    // Types
    typedef enum logic [2:0] {
        MRCR_POWER_DOWN = 3'b001,
        MRCR_SINGLE = 3'b010,
        MRCR_CONTINUOUS = 3'b100
    } mrcr_mode_t;

    typedef struct packed {
        logic signed [RAW_W-1:0] x;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] z;
    } mrcr_raw_t;

    typedef struct packed {
        logic x;
        logic y;
        logic z;
        logic v;
    } mrcr_switch_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [WDATA_W-1:0] wdata;
    } mrcr_req_t;
endpackage

/* File: rtl/mrcr_clamp.sv */
// Range dependent saturation of one axis sample
`timescale 1ns/1ps
`default_nettype none
module mrcr_clamp
    import mrcr_pkg::*;
(
    input wire logic signed [RAW_W-1:0] raw,
    input wire logic wide_range,
    input wire logic is_z,
    output logic signed [AXIS_W-1:0] value,
    output logic overflow
);
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;

    // ==========================================
    // Limits
    always_comb begin
        if (wide_range && !is_z) begin
            hi = WIDE_XY_HI;
            lo = WIDE_XY_LO;
        end else begin
            // Z keeps the full codes in both ranges, only its weight changes
            hi = FULL_HI;
            lo = FULL_LO;
        end
    end

    // ==========================================
    // Saturation; equal to a limit is not an overflow
    always_comb begin
        if (raw > hi) begin
            value = hi[AXIS_W-1:0];
            overflow = 1'b1;
        end else if (raw < lo) begin
            value = lo[AXIS_W-1:0];
            overflow = 1'b1;
        end else begin
            value = raw[AXIS_W-1:0];
            overflow = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mrcr_top.sv */
// Result and control registers of the magnetometer, link side on its own clock
`timescale 1ns/1ps
`default_nettype none
module mrcr_top
    import mrcr_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_clock,
    input wire logic link_req_valid,
    input wire logic link_req_write,
    input wire logic [ADDR_W-1:0] link_req_addr,
    input wire logic [WDATA_W-1:0] link_req_wdata,
    output logic link_ready,
    output logic link_rvalid,
    output logic [VEC_W-1:0] link_rdata,
    input wire logic sample_done,
    input wire mrcr_raw_t sample_raw,
    input wire mrcr_switch_t switch_state,
    output mrcr_mode_t meas_mode,
    output logic [2:0] continuous_rate,
    output logic drive_select,
    output logic range_select,
    output logic self_test_enable,
    input wire logic open_drain_interrupt_pin_in,
    output logic open_drain_interrupt_pin_out,
    output logic open_drain_interrupt_pin_oe
);
    // ==========================================
    // Functions
    function automatic logic [VEC_W-1:0] square(input logic signed [AXIS_W-1:0] v);
        logic signed [VEC_W-1:0] w;
        w = VEC_W'(v);
        return VEC_W'(w * w);
    endfunction

    function automatic logic is_result_addr(input logic [ADDR_W-1:0] a);
        return (a == X_RESULT_ADDR) || (a == Y_RESULT_ADDR) ||
               (a == Z_RESULT_ADDR) || (a == VECTOR_RESULT_ADDR);
    endfunction

    // ==========================================
    // Link domain: request capture
    mrcr_req_t link_req;
    logic link_req_toggle;
    logic link_ack_s1;
    logic link_ack_s2;
    logic link_ack_s3;
    logic link_done;
    logic [VEC_W-1:0] core_rdata;
    logic core_ack_toggle;

    assign link_done = link_ack_s2 ^ link_ack_s3;

    // Ack toggle crosses back through two flops
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            link_ack_s1 <= 1'b0;
            link_ack_s2 <= 1'b0;
            link_ack_s3 <= 1'b0;
        end else begin
            link_ack_s1 <= core_ack_toggle;
            link_ack_s2 <= link_ack_s1;
            link_ack_s3 <= link_ack_s2;
        end
    end

    // Request is held stable until the ack returns; new requests are ignored meanwhile
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            link_req <= '0;
            link_req_toggle <= 1'b0;
            link_ready <= 1'b1;
        end else if (link_ready && link_req_valid) begin
            link_req.write <= link_req_write;
            link_req.addr <= link_req_addr;
            link_req.wdata <= link_req_wdata;
            link_req_toggle <= ~link_req_toggle;
            link_ready <= 1'b0;
        end else if (link_done) begin
            link_ready <= 1'b1;
        end
    end

    // Read data held in core domain stays stable while the ack crosses
    always_ff @(posedge link_clock or negedge resetn) begin
        if (!resetn) begin
            link_rvalid <= 1'b0;
            link_rdata <= '0;
        end else begin
            link_rvalid <= link_done && !link_req.write;
            if (link_done && !link_req.write) begin
                link_rdata <= core_rdata;
            end
        end
    end

    // ==========================================
    // Core domain: request reception
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic take;
    logic take_write;
    logic take_read;
    logic result_read;
    logic setting_access;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= link_req_toggle;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    assign take = req_s2 ^ req_s3;
    assign take_write = take && link_req.write;
    assign take_read = take && !link_req.write;
    assign result_read = take_read && is_result_addr(link_req.addr);
    assign setting_access = take && (link_req.addr >= INT_CFG_ADDR) &&
                            (link_req.addr <= SETTING_LAST_ADDR);

    // ==========================================
    // Configuration registers
    logic [15:0] int_cfg;
    logic [7:0] mode_cfg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            int_cfg <= INT_CFG_RESET;
            mode_cfg <= MODE_CFG_RESET;
        end else if (take_write) begin
            if (link_req.addr == INT_CFG_ADDR) begin
                // Reserved and unused bits are never stored, so they read zero
                int_cfg <= link_req.wdata & INT_CFG_WMASK;
            end
            if (link_req.addr == MODE_CFG_ADDR) begin
                mode_cfg <= link_req.wdata[7:0];
            end
        end
    end

    // ==========================================
    // Mode decode and front-end settings
    logic [4:0] mode_code;
    mrcr_mode_t next_meas_mode;
    logic [2:0] next_rate;

    assign mode_code = mode_cfg[MODE_MSB:MODE_LSB];

    always_comb begin
        next_rate = 3'h0;
        if (mode_code == MODE_SINGLE) begin
            next_meas_mode = MRCR_SINGLE;
        end else if (!mode_code[0] && mode_code != 5'h00 && mode_code <= MODE_CONT_LAST) begin
            next_meas_mode = MRCR_CONTINUOUS;
            next_rate = 3'(mode_code[4:1] - 4'h1);
        end else begin
            next_meas_mode = MRCR_POWER_DOWN;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meas_mode <= MRCR_POWER_DOWN;
            continuous_rate <= 3'h0;
            drive_select <= 1'b0;
            range_select <= 1'b0;
            self_test_enable <= 1'b0;
        end else begin
            meas_mode <= next_meas_mode;
            continuous_rate <= next_rate;
            drive_select <= mode_cfg[DRIVE_BIT];
            range_select <= mode_cfg[RANGE_BIT];
            self_test_enable <= mode_cfg[SELF_TEST_BIT];
        end
    end

    // ==========================================
    // Saturation of the incoming sample
    logic signed [AXIS_W-1:0] clamp_x;
    logic signed [AXIS_W-1:0] clamp_y;
    logic signed [AXIS_W-1:0] clamp_z;
    logic ovf_x;
    logic ovf_y;
    logic ovf_z;

    mrcr_clamp u_clamp_x (
        .raw(sample_raw.x),
        .wide_range(mode_cfg[RANGE_BIT]),
        .is_z(1'b0),
        .value(clamp_x),
        .overflow(ovf_x)
    );

    mrcr_clamp u_clamp_y (
        .raw(sample_raw.y),
        .wide_range(mode_cfg[RANGE_BIT]),
        .is_z(1'b0),
        .value(clamp_y),
        .overflow(ovf_y)
    );

    mrcr_clamp u_clamp_z (
        .raw(sample_raw.z),
        .wide_range(mode_cfg[RANGE_BIT]),
        .is_z(1'b1),
        .value(clamp_z),
        .overflow(ovf_z)
    );

    // ==========================================
    // Result registers
    logic signed [AXIS_W-1:0] x_axis_result;
    logic signed [AXIS_W-1:0] y_axis_result;
    logic signed [AXIS_W-1:0] z_axis_result;
    logic [VEC_W-1:0] vector_magnitude_result;
    logic overflow_flag;

    // Vector is built from the clamped values so all four describe one sample
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            x_axis_result <= '0;
            y_axis_result <= '0;
            z_axis_result <= '0;
            vector_magnitude_result <= '0;
            overflow_flag <= 1'b0;
        end else if (sample_done) begin
            x_axis_result <= clamp_x;
            y_axis_result <= clamp_y;
            z_axis_result <= clamp_z;
            vector_magnitude_result <= square(clamp_x) + square(clamp_y) + square(clamp_z);
            overflow_flag <= ovf_x | ovf_y | ovf_z;
        end
    end

    // ==========================================
    // Data-ready and overrun
    logic data_ready_flag;
    logic overrun_flag;
    logic read_since;
    logic skipped;

    assign skipped = sample_done && meas_mode == MRCR_CONTINUOUS &&
                     data_ready_flag && !(result_read || setting_access);

    // A completion in the same cycle as a clearing access wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_ready_flag <= 1'b0;
        end else if (sample_done) begin
            data_ready_flag <= 1'b1;
        end else if (result_read || setting_access) begin
            data_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overrun_flag <= 1'b0;
            read_since <= 1'b0;
        end else begin
            if (skipped) begin
                overrun_flag <= 1'b1;
            end else if (sample_done && (read_since || result_read)) begin
                overrun_flag <= 1'b0;
            end
            if (sample_done) begin
                read_since <= 1'b0;
            end else if (result_read) begin
                read_since <= 1'b1;
            end
        end
    end

    // ==========================================
    // Read multiplexer
    logic [VEC_W-1:0] next_rdata;

    always_comb begin
        case (link_req.addr)
            STATUS_ADDR: begin
                next_rdata = VEC_W'(ST_FIXED);
                next_rdata[ST_DATA_READY_FLAG_BIT] = data_ready_flag;
                next_rdata[ST_OVF_BIT] = overflow_flag;
                next_rdata[ST_OVERRUN_BIT] = overrun_flag;
            end
            X_RESULT_ADDR: next_rdata = VEC_W'(unsigned'(x_axis_result));
            Y_RESULT_ADDR: next_rdata = VEC_W'(unsigned'(y_axis_result));
            Z_RESULT_ADDR: next_rdata = VEC_W'(unsigned'(z_axis_result));
            VECTOR_RESULT_ADDR: next_rdata = vector_magnitude_result;
            INT_CFG_ADDR: next_rdata = VEC_W'(int_cfg);
            MODE_CFG_ADDR: next_rdata = VEC_W'(mode_cfg);
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            core_rdata <= '0;
            core_ack_toggle <= 1'b0;
        end else if (take) begin
            core_rdata <= next_rdata;
            core_ack_toggle <= ~core_ack_toggle;
        end
    end

    // ==========================================
    // Interrupt pin
    // Open drain can only pull low; an active-high event releases the pin
    logic [3:0] sw_active;
    logic [3:0] sw_pull;
    logic base_pull;

    assign sw_active = {switch_state.v & int_cfg[V_SW_EN_BIT],
                        switch_state.z & int_cfg[Z_SW_EN_BIT],
                        switch_state.y & int_cfg[Y_SW_EN_BIT],
                        switch_state.x & int_cfg[X_SW_EN_BIT]};
    assign sw_pull = sw_active ^ {int_cfg[V_POL_BIT], int_cfg[Z_POL_BIT],
                                  int_cfg[Y_POL_BIT], int_cfg[X_POL_BIT]};
    // Data-ready and overflow share the X polarity
    assign base_pull = ((data_ready_flag & int_cfg[DATA_READY_FLAG_EN_BIT]) |
                        (overflow_flag & int_cfg[OVF_EN_BIT])) ^
                       int_cfg[X_POL_BIT];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            open_drain_interrupt_pin_oe <= 1'b0;
            open_drain_interrupt_pin_out <= 1'b0;
        end else begin
            open_drain_interrupt_pin_oe <= (|sw_pull) | base_pull;
            open_drain_interrupt_pin_out <= 1'b0;
        end
    end

    // Pin level is not needed internally; kept for board readback
    logic unused_pin;
    assign unused_pin = open_drain_interrupt_pin_in;
endmodule
`default_nettype wire

/* File: bench/mrcr_properties.sv */
// Concurrent checks on the ports of the result and control register block
`timescale 1ns/1ps
`default_nettype none
module mrcr_properties
    import mrcr_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_clock,
    input wire logic link_req_valid,
    input wire logic link_ready,
    input wire logic link_rvalid,
    input wire logic [VEC_W-1:0] link_rdata,
    input wire mrcr_mode_t meas_mode,
    input wire logic [2:0] continuous_rate,
    input wire logic drive_select,
    input wire logic range_select,
    input wire logic self_test_enable,
    input wire logic open_drain_interrupt_pin_out
);
    // ==========================================
    // Link handshake
    ready_drop_a: assert property (@(posedge link_clock) disable iff (!resetn)
        link_req_valid && link_ready |=> !link_ready) else $error("request not taken");
    ready_return_a: assert property (@(posedge link_clock) disable iff (!resetn)
        $fell(link_ready) |-> ##[1:40] link_ready) else $error("access never answered");
    ready_idle_a: assert property (@(posedge link_clock) disable iff (!resetn)
        link_ready && !link_req_valid |=> link_ready) else $error("ready dropped when idle");
    rvalid_pulse_a: assert property (@(posedge link_clock) disable iff (!resetn)
        link_rvalid |-> link_ready ##1 !link_rvalid) else $error("read answer malformed");
    rdata_hold_a: assert property (@(posedge link_clock) disable iff (!resetn)
        !link_rvalid |-> link_rdata == $past(link_rdata)) else $error("read data moved");
    // Settings lag the returned ack by a core cycle, so only a longer idle spell must be quiet
    cfg_quiet_a: assert property (
        @(posedge link_clock) disable iff (!resetn) link_ready [*4]
        |-> $stable({meas_mode, continuous_rate, drive_select, range_select, self_test_enable}))
        else $error("settings changed without access");
    // ==========================================
    // Core side
    mode_rate_a: assert property (@(posedge clock) disable iff (!resetn)
        meas_mode != MRCR_CONTINUOUS |-> continuous_rate == 3'h0) else $error("stray rate");
    mode_onehot_a: assert property (@(posedge clock) disable iff (!resetn)
        $onehot(meas_mode)) else $error("mode not one-hot");
    pin_low_only_a: assert property (@(posedge clock) disable iff (!resetn)
        open_drain_interrupt_pin_out == 1'b0) else $error("pin driven high");
endmodule
bind mrcr_top mrcr_properties chk_u (
    .clock(clock), .resetn(resetn), .link_clock(link_clock),
    .link_req_valid(link_req_valid), .link_ready(link_ready), .link_rvalid(link_rvalid),
    .link_rdata(link_rdata), .meas_mode(meas_mode), .continuous_rate(continuous_rate),
    .drive_select(drive_select), .range_select(range_select),
    .self_test_enable(self_test_enable),
    .open_drain_interrupt_pin_out(open_drain_interrupt_pin_out)
);
`default_nettype wire

/* File: bench/mrcr_host_model.sv */
// Host model issuing register accesses over the link port
`timescale 1ns/1ps
`default_nettype none
module mrcr_host_model
    import mrcr_pkg::*;
(
    input wire logic link_clock,
    input wire logic link_ready,
    input wire logic link_rvalid,
    input wire logic [VEC_W-1:0] link_rdata,
    output logic link_req_valid,
    output logic link_req_write,
    output logic [ADDR_W-1:0] link_req_addr,
    output logic [WDATA_W-1:0] link_req_wdata
);
    int gap = 0;
    initial begin
        link_req_valid = 1'b0;
        link_req_write = 1'b0;
        link_req_addr = 8'h00;
        link_req_wdata = 16'h0000;
    end
    // ==========================================
    // One access, held until the edge that takes it
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                          output logic [31:0] rd, output bit ok);
        int n;
        ok = 1'b0;
        rd = 32'h0000_0000;
        repeat (gap) @(negedge link_clock);
        @(negedge link_clock);
        link_req_valid = 1'b1;
        link_req_write = wr;
        link_req_addr = a;
        link_req_wdata = (a == INT_CFG_ADDR) ? (wd & 16'hdfff) : wd;
        for (n = 0; n < 60 && !ok; n++) begin
            @(posedge link_clock);
            ok = link_ready;
        end
        if (ok) begin
            @(negedge link_clock);
            link_req_valid = 1'b0;
            // Released lines flip so a stale value cannot pass
            link_req_addr = ~a;
            link_req_wdata = ~wd;
            ok = 1'b0;
            for (n = 0; n < 60 && !ok; n++) begin
                @(posedge link_clock);
                ok = link_ready && (wr || link_rvalid);
                rd = link_rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/mrcr_top_test.sv */
// Self-checking testbench of the result and control register block
`timescale 1ns/1ps
`default_nettype none
module mrcr_top_test
    import mrcr_pkg::*;
;
    localparam logic [7:0] RA [6] = '{X_RESULT_ADDR, Y_RESULT_ADDR, Z_RESULT_ADDR,
        VECTOR_RESULT_ADDR, INT_CFG_ADDR, MODE_CFG_ADDR};
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic resetn = 1'b0;
    logic sample_done = 1'b0;
    mrcr_raw_t sample_raw = '0;
    mrcr_switch_t switch_state = '0;
    logic link_req_valid, link_req_write, link_ready, link_rvalid, pin_out, pin_oe;
    logic [ADDR_W-1:0] link_req_addr;
    logic [WDATA_W-1:0] link_req_wdata;
    logic [VEC_W-1:0] link_rdata;
    mrcr_mode_t meas_mode;
    logic [2:0] continuous_rate;
    logic drive_select, range_select, self_test_enable;
    wire logic pin_level;
    int n_fail = 0;
    int n_compared = 0;
    // Pull-up on the open-drain pin
    assign pin_level = pin_oe ? 1'b0 : 1'b1;
    always #25 clock = ~clock;
    initial begin
        #3.1;
        forever #7.5 link_clock = ~link_clock;
    end
    mrcr_top dut_u (
        .clock(clock), .resetn(resetn), .link_clock(link_clock),
        .link_req_valid(link_req_valid), .link_req_write(link_req_write),
        .link_req_addr(link_req_addr), .link_req_wdata(link_req_wdata),
        .link_ready(link_ready), .link_rvalid(link_rvalid), .link_rdata(link_rdata),
        .sample_done(sample_done), .sample_raw(sample_raw), .switch_state(switch_state),
        .meas_mode(meas_mode), .continuous_rate(continuous_rate),
        .drive_select(drive_select), .range_select(range_select),
        .self_test_enable(self_test_enable), .open_drain_interrupt_pin_in(pin_level),
        .open_drain_interrupt_pin_out(pin_out), .open_drain_interrupt_pin_oe(pin_oe)
    );
    mrcr_host_model host_u (
        .link_clock(link_clock), .link_ready(link_ready), .link_rvalid(link_rvalid),
        .link_rdata(link_rdata), .link_req_valid(link_req_valid),
        .link_req_write(link_req_write), .link_req_addr(link_req_addr),
        .link_req_wdata(link_req_wdata)
    );
    // ==========================================
    // Shared tasks
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [31:0] r);
        bit ok;
        host_u.access(w, a, d, r, ok);
        if (!ok) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        acc(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        acc(1'b0, a, 16'h0000, r);
        chk(r, e);
    endtask
    task automatic smp(input logic [19:0] x, input logic [19:0] y, input logic [19:0] z);
        @(negedge clock);
        sample_raw = {x, y, z};
        sample_done = 1'b1;
        @(negedge clock);
        sample_done = 1'b0;
    endtask
    task automatic res_chk(input int x, input int y, input int z);
        rd_chk(X_RESULT_ADDR, {16'h0000, 16'(x)});
        rd_chk(Y_RESULT_ADDR, {16'h0000, 16'(y)});
        rd_chk(Z_RESULT_ADDR, {16'h0000, 16'(z)});
        rd_chk(VECTOR_RESULT_ADDR, 32'(x * x + y * y + z * z));
    endtask
    task automatic pin_chk(input logic e);
        repeat (2) @(negedge clock);
        chk(32'(pin_oe), 32'(e));
    endtask
    // ==========================================
    // Main sequence
    initial begin
        int i;
        mrcr_mode_t e_mode;
        logic [31:0] e_rate;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(posedge link_clock);
        chk(32'(meas_mode), 32'(MRCR_POWER_DOWN));
        for (i = 0; i < 6; i++) rd_chk(RA[i], 32'h0000_0000);
        rd_chk(STATUS_ADDR, 32'h0000_0080);
        for (i = 0; i < 32; i++) begin
            host_u.gap = i % 3;
            wr(MODE_CFG_ADDR, 16'(i));
            // Decoded settings register a core cycle after the ack may already be back
            repeat (2) @(negedge clock);
            e_mode = (i == 1) ? MRCR_SINGLE : MRCR_POWER_DOWN;
            e_rate = 32'h0000_0000;
            if (i % 2 == 0 && i >= 2 && i <= 16) begin
                e_mode = MRCR_CONTINUOUS;
                e_rate = 32'(i / 2 - 1);
            end
            chk(32'(meas_mode), 32'(e_mode));
            chk(32'(continuous_rate), e_rate);
            rd_chk(MODE_CFG_ADDR, 32'(i));
        end
        wr(MODE_CFG_ADDR, 16'h00e0);
        repeat (2) @(negedge clock);
        chk(32'(drive_select), 32'h0000_0001);
        chk(32'(range_select), 32'h0000_0001);
        chk(32'(self_test_enable), 32'h0000_0001);
        rd_chk(MODE_CFG_ADDR, 32'h0000_00e0);
        wr(INT_CFG_ADDR, 16'hdfff);
        rd_chk(INT_CFG_ADDR, 32'h0000_0f3f);
        rd_chk(8'h30, 32'h0000_0000);
        wr(X_RESULT_ADDR, 16'h1234);
        rd_chk(X_RESULT_ADDR, 32'h0000_0000);
        wr(MODE_CFG_ADDR, 16'h0001);
        smp(20'h4_0000, 20'hf_8000, 20'h0_0001);
        rd_chk(STATUS_ADDR, 32'h0000_00a1);
        res_chk(32767, -32768, 1);
        rd_chk(STATUS_ADDR, 32'h0000_00a0);
        smp(20'h0_7fff, 20'hf_0000, 20'hf_ffff);
        res_chk(32767, -32768, -1);
        wr(MODE_CFG_ADDR, 16'h0041);
        smp(20'h0_2c01, 20'hf_b1e0, 20'h0_9c40);
        rd_chk(STATUS_ADDR, 32'h0000_00a1);
        res_chk(11264, -11264, 32767);
        smp(20'h0_2c00, 20'hf_d400, 20'hf_8000);
        rd_chk(STATUS_ADDR, 32'h0000_0081);
        res_chk(11264, -11264, -32768);
        wr(MODE_CFG_ADDR, 16'h0002);
        smp(20'h0_0003, 20'hf_fffc, 20'h0_0005);
        smp(20'h0_0003, 20'hf_fffc, 20'h0_0005);
        rd_chk(STATUS_ADDR, 32'h0000_00c1);
        res_chk(3, -4, 5);
        smp(20'h0_0001, 20'h0_0002, 20'h0_0003);
        rd_chk(STATUS_ADDR, 32'h0000_0081);
        for (i = 0; i < 4; i++) begin
            wr(INT_CFG_ADDR, 16'(2 << i));
            switch_state = mrcr_switch_t'(4'b1000 >> i);
            pin_chk(1'b1);
            wr(INT_CFG_ADDR, 16'((2 << i) | (256 << i)));
            // Idle data-ready line shares X polarity, so it holds the pin low for X
            pin_chk(i == 0);
            switch_state = 4'b0000;
            pin_chk(1'b1);
            wr(INT_CFG_ADDR, 16'h0000);
            pin_chk(1'b0);
        end
        wr(INT_CFG_ADDR, 16'h0001);
        smp(20'h0_0000, 20'h0_0000, 20'h0_0000);
        pin_chk(1'b1);
        rd_chk(X_RESULT_ADDR, 32'h0000_0000);
        pin_chk(1'b0);
        smp(20'h4_0000, 20'h0_0000, 20'h0_0000);
        wr(INT_CFG_ADDR, 16'h0020);
        pin_chk(1'b1);
        wr(INT_CFG_ADDR, 16'h0000);
        pin_chk(1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
